// *** line_threshold_pkg.sv ***
// constants and types for the line threshold interrupt block
`default_nettype none
package line_threshold_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] THRESHOLD_VALUE_OFS   = 8'h2B;
   localparam logic [7:0] THRESHOLD_CONTROL_OFS = 8'h2C;
   localparam logic [7:0] IRQ_STATUS_OFS        = 8'h2D;
   localparam logic [7:0] IRQ_MASK_OFS          = 8'h2E;
   localparam logic [7:0] IRQ_ENABLE_OFS        = 8'h2F;
   localparam logic [7:0] MEASURE_VIEW_OFS      = 8'h30;

   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned CTRL_POLARITY_BIT = 0;
   localparam int unsigned CTRL_MASK_BIT     = 1;
   localparam int unsigned CTRL_SOURCE_BIT   = 2;
   localparam int unsigned CTRL_FLAG_BIT     = 3;
   localparam int unsigned STAT_CROSSING_BIT = 0;
   localparam int unsigned GLOBAL_EN_BIT     = 0;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] THRESHOLD_VALUE_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST         = 8'h00;
   localparam logic       GLOBAL_EN_RST       = 1'b0;
   localparam logic [7:0] READ_ZERO           = 8'h00;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic source_select;
      logic threshold_irq_mask;
      logic trigger_polarity;
   } ctrl_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] value;
   } meas_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } reg_req_t;

endpackage : line_threshold_pkg
`default_nettype wire

// *** line_threshold_interrupt.sv ***
// threshold compare of line measurement with sticky flag and interrupt
//
// Behaviour
// - an eight-bit software threshold is the reference for the comparison
// - source select 0 compares loop current, 1 compares line voltage
// - polarity 0 triggers when the absolute measurement is below threshold
// - polarity 1 triggers when the absolute measurement is above threshold
// - a trigger sets the crossing flag; 0 means no crossing since clear
// - the flag stays set until software writes 0 to control bit 3 or 1 to status bit 0; never self-clears
// - interrupt output only when flag, mask and global enable are all 1
// - with mask 0 a trigger still sets the flag but no interrupt
//
// Implementation choice: the plain strobed port.
`default_nettype none
module line_threshold_interrupt
   import line_threshold_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_we_i,
   input  wire logic       reg_re_i,
   output logic      [7:0] reg_rdata_o,
   // measurements, two's complement, with update strobes
   input  wire logic [7:0] loop_current_measure_i,
   input  wire logic       loop_current_valid_i,
   input  wire logic [7:0] line_voltage_measure_i,
   input  wire logic       line_voltage_valid_i,
   // interrupt
   output logic            shared_irq_output_o
);

   // ****************************************
   // request and measurement carriers
   // ****************************************
   reg_req_t   req;
   meas_t      lc_meas;
   meas_t      lv_meas;
   meas_t      sel_meas;
   ctrl_t      ctrl_q;
   logic [7:0] threshold_value_q;
   logic       crossing_flag_q;
   logic       global_irq_enable_q;
   logic [7:0] last_abs_q;
   logic [7:0] sel_abs;
   logic       trigger;
   logic       flag_clear;
   logic       hit_value;
   logic       hit_control;
   logic       hit_status;
   logic       hit_mask;
   logic       hit_enable;
   logic       hit_view;
   logic [7:0] read_mux;

   assign req      = '{addr: reg_addr_i, wdata: reg_wdata_i, we: reg_we_i, re: reg_re_i};
   assign lc_meas  = '{valid: loop_current_valid_i, value: loop_current_measure_i};
   assign lv_meas  = '{valid: line_voltage_valid_i, value: line_voltage_measure_i};

   // ****************************************
   // address decode
   // ****************************************
   always_comb
   begin
      hit_value   = 1'b0;
      hit_control = 1'b0;
      hit_status  = 1'b0;
      hit_mask    = 1'b0;
      hit_enable  = 1'b0;
      hit_view    = 1'b0;
      if (req.addr == THRESHOLD_VALUE_OFS)
      begin
         hit_value = 1'b1;
      end
      else if (req.addr == THRESHOLD_CONTROL_OFS)
      begin
         hit_control = 1'b1;
      end
      else if (req.addr == IRQ_STATUS_OFS)
      begin
         hit_status = 1'b1;
      end
      else if (req.addr == IRQ_MASK_OFS)
      begin
         hit_mask = 1'b1;
      end
      else if (req.addr == IRQ_ENABLE_OFS)
      begin
         hit_enable = 1'b1;
      end
      else if (req.addr == MEASURE_VIEW_OFS)
      begin
         hit_view = 1'b1;
      end
   end

   // ****************************************
   // threshold register
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         threshold_value_q <= THRESHOLD_VALUE_RST;
      end
      else if (req.we && hit_value)
      begin
         threshold_value_q <= req.wdata;
      end
   end

   // ****************************************
   // control fields
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         ctrl_q <= ctrl_t'(CONTROL_RST[2:0]);
      end
      else if (req.we && hit_control)
      begin
         ctrl_q.source_select      <= req.wdata[CTRL_SOURCE_BIT];
         ctrl_q.threshold_irq_mask <= req.wdata[CTRL_MASK_BIT];
         ctrl_q.trigger_polarity   <= req.wdata[CTRL_POLARITY_BIT];
      end
      else if (req.we && hit_mask)
      begin
         ctrl_q.threshold_irq_mask <= req.wdata[STAT_CROSSING_BIT];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         global_irq_enable_q <= GLOBAL_EN_RST;
      end
      else if (req.we && hit_enable)
      begin
         global_irq_enable_q <= req.wdata[GLOBAL_EN_BIT];
      end
   end

   // ****************************************
   // source select and compare
   // ****************************************
   always_comb
   begin
      sel_meas = ctrl_q.source_select ? lv_meas : lc_meas;
      sel_abs  = sel_meas.value[7] ? 8'(-sel_meas.value) : sel_meas.value;
      trigger  = 1'b0;
      if (sel_meas.valid)
      begin
         if (ctrl_q.trigger_polarity)
         begin
            trigger = (sel_abs > threshold_value_q);
         end
         else
         begin
            trigger = (sel_abs < threshold_value_q);
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         last_abs_q <= READ_ZERO;
      end
      else if (sel_meas.valid)
      begin
         last_abs_q <= sel_abs;
      end
   end

   // ****************************************
   // crossing flag
   // ****************************************
   assign flag_clear = req.we && ((hit_control && !req.wdata[CTRL_FLAG_BIT])
                    || (hit_status && req.wdata[STAT_CROSSING_BIT]));

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         crossing_flag_q <= 1'b0;
      end
      else if (trigger)
      begin
         crossing_flag_q <= 1'b1;
      end
      else if (flag_clear)
      begin
         crossing_flag_q <= 1'b0;
      end
   end

   // ****************************************
   // interrupt output
   // ****************************************
   assign shared_irq_output_o = crossing_flag_q && ctrl_q.threshold_irq_mask
                              && global_irq_enable_q;

   // ****************************************
   // read data
   // ****************************************
   always_comb
   begin
      read_mux = READ_ZERO;
      if (hit_value)
      begin
         read_mux = threshold_value_q;
      end
      else if (hit_control)
      begin
         read_mux = {4'h0, crossing_flag_q, ctrl_q.source_select,
                     ctrl_q.threshold_irq_mask, ctrl_q.trigger_polarity};
      end
      else if (hit_status)
      begin
         read_mux = {7'h00, crossing_flag_q};
      end
      else if (hit_mask)
      begin
         read_mux = {7'h00, ctrl_q.threshold_irq_mask};
      end
      else if (hit_enable)
      begin
         read_mux = {7'h00, global_irq_enable_q};
      end
      else if (hit_view)
      begin
         read_mux = last_abs_q;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o <= READ_ZERO;
      end
      else if (req.re)
      begin
         reg_rdata_o <= read_mux;
      end
      else
      begin
         reg_rdata_o <= READ_ZERO;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence seq_thr_write;
      req.we && hit_value;
   endsequence

   sequence seq_below;
      sel_meas.valid && !ctrl_q.trigger_polarity && (sel_abs < threshold_value_q);
   endsequence

   sequence seq_above;
      sel_meas.valid && ctrl_q.trigger_polarity && (sel_abs > threshold_value_q);
   endsequence

   AST_THRESHOLD_STORED: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      seq_thr_write |=> (threshold_value_q == $past(req.wdata)))
      else $error("threshold not stored");

   AST_SOURCE_LOOP: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!ctrl_q.source_select && loop_current_valid_i && !loop_current_measure_i[7]
       && !ctrl_q.trigger_polarity && loop_current_measure_i < threshold_value_q)
      |=> crossing_flag_q)
      else $error("loop current source not compared");

   AST_BELOW_SETS: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      seq_below |=> crossing_flag_q)
      else $error("below threshold did not set flag");

   AST_ABOVE_SETS: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      seq_above |=> crossing_flag_q)
      else $error("above threshold did not set flag");

   AST_SET_HAS_CAUSE: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      $rose(crossing_flag_q) |-> $past(sel_meas.valid && (ctrl_q.trigger_polarity
         ? (sel_abs > threshold_value_q) : (sel_abs < threshold_value_q))))
      else $error("flag set without a crossing");

   AST_FLAG_STICKY: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (crossing_flag_q && !flag_clear) |=> crossing_flag_q)
      else $error("flag cleared without a write");

   AST_IRQ_NEEDS_ALL: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      shared_irq_output_o |-> (crossing_flag_q && ctrl_q.threshold_irq_mask
                               && global_irq_enable_q))
      else $error("interrupt without flag and enable");

   AST_MASKED_QUIET: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!ctrl_q.threshold_irq_mask && !(req.we && (hit_control || hit_mask))
       ##0 (seq_below or seq_above))
      |=> (crossing_flag_q && !shared_irq_output_o))
      else $error("masked trigger misbehaved");

   AST_IRQ_HOLDS: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (shared_irq_output_o && !flag_clear && !req.we) |=> shared_irq_output_o)
      else $error("interrupt dropped while conditions hold");

endmodule // line_threshold_interrupt
`default_nettype wire

// *** meas_source_model.sv ***
// partner model of the measurement front end feeding the threshold block
`default_nettype none
module meas_source_model
(
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   // command from the bench
   input  wire logic       send_i,
   input  wire logic       sel_i,
   input  wire logic [7:0] value_i,
   // measurement outputs
   output logic      [7:0] loop_current_measure_o,
   output logic            loop_current_valid_o,
   output logic      [7:0] line_voltage_measure_o,
   output logic            line_voltage_valid_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // one-cycle update strobe, data toggles when not updating
   // ****************************************
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         loop_current_measure_o <= 8'h00;
         line_voltage_measure_o <= 8'h00;
         loop_current_valid_o   <= 1'b0;
         line_voltage_valid_o   <= 1'b0;
      end
      else
      begin
         loop_current_valid_o   <= send_i && !sel_i;
         line_voltage_valid_o   <= send_i && sel_i;
         loop_current_measure_o <= (send_i && !sel_i) ? value_i : ~loop_current_measure_o;
         line_voltage_measure_o <= (send_i && sel_i) ? value_i : ~line_voltage_measure_o;
      end
   end
endmodule // meas_source_model
`default_nettype wire

// *** line_threshold_interrupt_bench.sv ***
// self-checking testbench of the line threshold interrupt block
`default_nettype none
module line_threshold_interrupt_bench;
   import line_threshold_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk_sys_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_we    = 1'b0;
   logic       reg_re    = 1'b0;
   logic [7:0] reg_rdata;
   logic       send      = 1'b0;
   logic       sel       = 1'b0;
   logic [7:0] value     = 8'h00;
   logic [7:0] lc_meas;
   logic       lc_valid;
   logic [7:0] lv_meas;
   logic       lv_valid;
   logic       irq;
   int         n_fail    = 0;
   int         tests_run = 0;
   int         cycles    = 0;
   logic [7:0] c_tab [10] = '{8'h02, 8'h02, 8'h02, 8'h06, 8'h06,
                              8'h07, 8'h07, 8'h07, 8'h03, 8'h01};
   logic       s_tab [10] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0] v_tab [10] = '{8'hF8, 8'h10, 8'h00, 8'h05, 8'h05,
                              8'h11, 8'h80, 8'h0F, 8'hF0, 8'h20};
   logic       f_tab [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   // ****************************************
   // clock, instances and timeout
   // ****************************************
   initial
   begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   line_threshold_interrupt i_line_threshold_interrupt (
      .clk_sys_i              (clk_sys_i),
      .rst_i                  (rst_i),
      .reg_addr_i             (reg_addr),
      .reg_wdata_i            (reg_wdata),
      .reg_we_i               (reg_we),
      .reg_re_i               (reg_re),
      .reg_rdata_o            (reg_rdata),
      .loop_current_measure_i (lc_meas),
      .loop_current_valid_i   (lc_valid),
      .line_voltage_measure_i (lv_meas),
      .line_voltage_valid_i   (lv_valid),
      .shared_irq_output_o    (irq)
   );

   meas_source_model i_meas_source_model (
      .clk_sys_i              (clk_sys_i),
      .rst_i                  (rst_i),
      .send_i                 (send),
      .sel_i                  (sel),
      .value_i                (value),
      .loop_current_measure_o (lc_meas),
      .loop_current_valid_o   (lc_valid),
      .line_voltage_measure_o (lv_meas),
      .line_voltage_valid_o   (lv_valid)
   );

   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         test_done();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys_i);
      reg_we    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys_i);
      reg_re   <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), e, reg_rdata);
      @(posedge clk_sys_i);
      #1;
      chk("rdata idle", READ_ZERO, reg_rdata);
   endtask

   task automatic meas(input logic s, input logic [7:0] v);
      @(posedge clk_sys_i);
      send  <= 1'b1;
      sel   <= s;
      value <= v;
      @(posedge clk_sys_i);
      send  <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial
   begin
      int i;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(THRESHOLD_VALUE_OFS, THRESHOLD_VALUE_RST);
      rd(THRESHOLD_CONTROL_OFS, CONTROL_RST);
      rd(8'h55, READ_ZERO);
      chk("irq", 8'h00, {7'h00, irq});
      wr(THRESHOLD_VALUE_OFS, 8'h10);
      rd(THRESHOLD_VALUE_OFS, 8'h10);
      wr(IRQ_ENABLE_OFS, 8'h01);
      for (i = 0; i < 10; i++)
      begin
         wr(THRESHOLD_CONTROL_OFS, c_tab[i]);
         meas(s_tab[i], v_tab[i]);
         rd(8'h2C, c_tab[i] | {4'h0, f_tab[i], 3'h0});
         chk("irq", {7'h00, f_tab[i] & c_tab[i][1]}, {7'h00, irq});
      end
      wr(THRESHOLD_CONTROL_OFS, 8'h02);
      meas(1'b0, 8'h01);
      repeat (30) @(posedge clk_sys_i);
      wr(THRESHOLD_CONTROL_OFS, 8'h0A);
      rd(8'h2C, 8'h0A);
      rd(8'h2D, 8'h01);
      chk("irq", 8'h01, {7'h00, irq});
      wr(IRQ_ENABLE_OFS, 8'h00);
      rd(8'h2C, 8'h0A);
      chk("irq", 8'h00, {7'h00, irq});
      wr(IRQ_ENABLE_OFS, 8'h01);
      rd(IRQ_ENABLE_OFS, 8'h01);
      chk("irq", 8'h01, {7'h00, irq});
      wr(THRESHOLD_CONTROL_OFS, 8'h02);
      rd(8'h2C, 8'h02);
      chk("irq", 8'h00, {7'h00, irq});
      meas(1'b0, 8'hF3);
      rd(MEASURE_VIEW_OFS, 8'h0D);
      wr(IRQ_MASK_OFS, 8'h00);
      rd(THRESHOLD_CONTROL_OFS, 8'h08);
      chk("irq", 8'h00, {7'h00, irq});
      wr(IRQ_MASK_OFS, 8'h01);
      rd(IRQ_MASK_OFS, 8'h01);
      chk("irq", 8'h01, {7'h00, irq});
      wr(IRQ_STATUS_OFS, 8'h01);
      rd(IRQ_STATUS_OFS, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      test_done();
   end
endmodule // line_threshold_interrupt_bench
`default_nettype wire
